/* core/bmd_cfg.svh */
// Constants for the banked data memory decode block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BMD_CFG_SVH
`define BMD_CFG_SVH

// Build variant: 0 = 80 entries, 1 = 96 entries, 2 = 128 entries
`define BMD_VAR_SMALL 2'h0
`define BMD_VAR_MID 2'h1
`define BMD_VAR_LARGE 2'h2
`define BMD_VARIANT 2'h2

// Storage geometry
`define BMD_GPR_DEPTH 128
`define BMD_GPR_AW 7
`define BMD_B0_DEPTH_SMALL 7'h50
`define BMD_B0_DEPTH_FULL 7'h60
`define BMD_B1_GPR_IDX_BASE 7'h60

// Bank layout, as offsets within a 128-location bank
`define BMD_GPR_BASE 7'h20
`define BMD_B1_GPR_LAST 7'h3F
`define BMD_COMMON_FIRST 7'h70

// Special function offsets handled here
`define BMD_OFF_INDIRECT 7'h00
`define BMD_OFF_STATUS 7'h03
`define BMD_OFF_POINTER 7'h04
`define BMD_BANK_BIT 5

// Other special function offsets decoded per bank, one bit per offset
`define BMD_SFR_MASK_B0 32'h80001C66
`define BMD_SFR_MASK_B1 32'h80005C66

// Reset values
`define BMD_STATUS_RST 8'h00
`define BMD_POINTER_RST 8'h00

// Bus layout: word index in paddr[8:2], paddr[11:9] must be zero
`define BMD_PADDR_W 12
`define BMD_IDX_LSB 2
`define BMD_IDX_MSB 8
`define BMD_HI_LSB 9
`define BMD_HI_MSB 11
`define BMD_BYTE_ZERO 24'h000000

`endif

/* core/bmd_pkg.sv */
// Types for the banked data memory decode block.
// Assumes bmd_cfg.svh is on the include path.
`include "bmd_cfg.svh"

package bmd_pkg;

    // Bus sequencer states, one-hot
    typedef enum logic [2:0] {
        BMD_ST_IDLE = 3'h1,
        BMD_ST_EXEC = 3'h2,
        BMD_ST_RESP = 3'h4
    } bmd_state_e;

    // Target of a decoded access
    typedef enum logic [2:0] {
        BMD_K_NONE = 3'h0,
        BMD_K_STATUS = 3'h1,
        BMD_K_POINTER = 3'h2,
        BMD_K_SFR = 3'h3,
        BMD_K_GPR = 3'h4
    } bmd_kind_e;

    typedef logic [`BMD_GPR_AW-1:0] bmd_gidx_t;

endpackage

/* core/bmd_gpr_if.sv */
// Carrier between the decode logic and the register file storage.
// Assumes both ends share pclk.
`timescale 1ns/100ps
`default_nettype none
`include "bmd_cfg.svh"

interface bmd_gpr_if;
    logic we;
    bmd_pkg::bmd_gidx_t widx;
    logic [7:0] wdata;
    bmd_pkg::bmd_gidx_t ridx;
    logic [7:0] rdata;

    // Decode side drives requests
    modport ctrl (output we, output widx, output wdata, output ridx, input rdata);
    // Storage side answers
    modport mem (input we, input widx, input wdata, input ridx, output rdata);
endinterface

`default_nettype wire

/* core/bmd_gpr_store.sv */
// General purpose register file storage, flip-flops addressed by index.
// Assumes a single writer on the carrier and the decode clock.
`timescale 1ns/100ps
`default_nettype none
`include "bmd_cfg.svh"

module bmd_gpr_store (
    // Clock
    input wire logic pclk,
    // Access carrier
    bmd_gpr_if.mem gpr
);

    logic [7:0] mem_r [`BMD_GPR_DEPTH];
    logic [7:0] mem_nxt [`BMD_GPR_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // One storage byte per entry
    for (genvar i = 0; i < `BMD_GPR_DEPTH; i++) begin : g_entry
        // Next value: write data on an index match
        always_comb begin
            mem_nxt[i] = mem_r[i];
            if (gpr.we && gpr.widx == `BMD_GPR_AW'(i)) begin
                mem_nxt[i] = gpr.wdata;
            end
        end

        // Static RAM, so no reset
        always_ff @(posedge pclk) begin
            mem_r[i] <= mem_nxt[i];
        end
    end

    // Read port
    assign gpr.rdata = mem_r[gpr.ridx];

endmodule

`default_nettype wire

/* core/bmd_decode.sv */
// Banked data memory decode: APB slave over the two data banks.
// Assumes an APB master that holds each request until pready is seen,
// and an external special function block answering sfr_rdata in the
// cycle that sfr_rd is high.
//
// Function
// - Status bit 5 selects bank 1
// - Low 32 locations per bank are special
// - Bank-0 20h-7Fh are general RAM, 20h-6Fh only on the small variant
// - Large variant adds bank-1 A0h-BFh RAM
// - Bank-1 F0h-FFh alias bank-0 70h-7Fh, except on the small variant where both map to no entry
// - Eight-bit file, 80/96/128 entries per variant
// - Every location reachable direct, and all but 00h/80h via pointer
// - Some special offsets decode only in bank 1
`timescale 1ns/100ps
`default_nettype none
`include "bmd_cfg.svh"

module bmd_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BMD_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Special function register side port
    output logic [7:0] sfr_addr,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Core state
    output logic bank_select_bit,
    output logic [7:0] machine_status,
    output logic [7:0] indirect_pointer
);

    ////////////////////////////////////////////////////////////////////////
    // State

    bmd_pkg::bmd_state_e state_r, state_nxt;
    bmd_pkg::bmd_kind_e kind_r, kind_nxt;
    bmd_pkg::bmd_gidx_t gidx_r, gidx_nxt;
    logic write_r, write_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [7:0] sfr_addr_r, sfr_addr_nxt;
    logic sfr_rd_r, sfr_rd_nxt;
    logic sfr_wr_r, sfr_wr_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] pointer_r, pointer_nxt;

    // Decode of the address in the setup cycle
    bmd_pkg::bmd_kind_e dec_kind;
    bmd_pkg::bmd_gidx_t dec_gidx;
    logic [7:0] dec_eff;
    logic dec_err;
    logic [7:0] gpr_hit;

    bmd_gpr_if gpr ();

    ////////////////////////////////////////////////////////////////////////
    // Map a full file address to a storage index, bit 7 = hit
    // Unlisted addresses map to no entry and so read zero

    function automatic logic [7:0] gpr_map(input logic [7:0] a);
        logic [6:0] off;
        logic [7:0] res;
        off = a[6:0] - `BMD_GPR_BASE;
        res = 8'h00;
        if (a[6:0] >= `BMD_GPR_BASE) begin
            if (!a[7]) begin
                // Bank 0 runs up from 20h for the variant depth
                if (`BMD_VARIANT == `BMD_VAR_SMALL) begin
                    if (off < `BMD_B0_DEPTH_SMALL) begin
                        res = {1'b1, off};
                    end
                end else begin
                    if (off < `BMD_B0_DEPTH_FULL) begin
                        res = {1'b1, off};
                    end
                end
            end else if (a[6:0] <= `BMD_B1_GPR_LAST) begin
                // Extra bank-1 block on the large variant only
                if (`BMD_VARIANT == `BMD_VAR_LARGE) begin
                    res = {1'b1, off + `BMD_B1_GPR_IDX_BASE};
                end
            end else if (a[6:0] >= `BMD_COMMON_FIRST) begin
                // Common RAM shares the bank-0 entries
                if (`BMD_VARIANT != `BMD_VAR_SMALL) begin
                    res = {1'b1, off};
                end
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address decode from the bus address and current bank state
    // Bank bit and pointer are used as they stand in the setup cycle;
    // a write to either lands before the next setup can be taken

    always_comb begin
        logic [6:0] doff;
        logic [31:0] mask;
        doff = paddr[`BMD_IDX_MSB:`BMD_IDX_LSB];
        mask = 32'h00000000;
        dec_err = 1'b0;
        dec_kind = bmd_pkg::BMD_K_NONE;
        // Indirect port takes the pointer as the whole address
        if (doff == `BMD_OFF_INDIRECT) begin
            dec_eff = pointer_r;
        end else begin
            dec_eff = {status_r[`BMD_BANK_BIT], doff};
        end
        mask = dec_eff[7] ? `BMD_SFR_MASK_B1 : `BMD_SFR_MASK_B0;
        gpr_hit = gpr_map(dec_eff);
        dec_gidx = gpr_hit[6:0];
        if (paddr[`BMD_HI_MSB:`BMD_HI_LSB] != 3'h0) begin
            // Outside the bus window
            dec_err = 1'b1;
        end else if (dec_eff[6:0] == `BMD_OFF_INDIRECT) begin
            // Pointer aimed at the port itself reaches nothing
            dec_kind = bmd_pkg::BMD_K_NONE;
        end else if (dec_eff[6:0] < `BMD_GPR_BASE) begin
            // Special function region
            if (dec_eff[6:0] == `BMD_OFF_STATUS) begin
                dec_kind = bmd_pkg::BMD_K_STATUS;
            end else if (dec_eff[6:0] == `BMD_OFF_POINTER) begin
                dec_kind = bmd_pkg::BMD_K_POINTER;
            end else if (mask[dec_eff[4:0]]) begin
                dec_kind = bmd_pkg::BMD_K_SFR;
            end
        end else if (gpr_hit[7]) begin
            dec_kind = bmd_pkg::BMD_K_GPR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage access during the execute cycle
    // One shared index for read and write; read data settles in execute,
    // so the answer needs no extra wait state

    assign gpr.ridx = gidx_r;
    assign gpr.widx = gidx_r;
    assign gpr.wdata = wdata_r;
    assign gpr.we = (state_r == bmd_pkg::BMD_ST_EXEC) && write_r
                    && (kind_r == bmd_pkg::BMD_K_GPR);

    bmd_gpr_store u_store (
        .pclk (pclk),
        .gpr (gpr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next values: setup, execute, answer
    // Setups seen while busy are ignored; the master holds them anyway

    always_comb begin
        logic [7:0] rbyte;
        rbyte = 8'h00;
        state_nxt = state_r;
        kind_nxt = kind_r;
        gidx_nxt = gidx_r;
        write_nxt = write_r;
        wdata_nxt = wdata_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        sfr_addr_nxt = sfr_addr_r;
        sfr_rd_nxt = 1'b0;
        sfr_wr_nxt = 1'b0;
        status_nxt = status_r;
        pointer_nxt = pointer_r;
        case (state_r)
            bmd_pkg::BMD_ST_IDLE: begin
                // Capture the request in its setup cycle
                if (psel && !penable) begin
                    kind_nxt = dec_kind;
                    gidx_nxt = dec_gidx;
                    write_nxt = pwrite;
                    wdata_nxt = pwdata[7:0];
                    pslverr_nxt = 1'b0;
                    state_nxt = dec_err ? bmd_pkg::BMD_ST_RESP : bmd_pkg::BMD_ST_EXEC;
                    // Error answer skips the execute cycle
                    if (dec_err) begin
                        kind_nxt = bmd_pkg::BMD_K_NONE;
                        pready_nxt = 1'b1;
                        pslverr_nxt = 1'b1;
                        prdata_nxt = 32'h00000000;
                    end
                    // Other special registers go to the side port
                    if (!dec_err && dec_kind == bmd_pkg::BMD_K_SFR) begin
                        sfr_addr_nxt = dec_eff;
                        sfr_rd_nxt = !pwrite;
                        sfr_wr_nxt = pwrite;
                    end
                end
            end
            bmd_pkg::BMD_ST_EXEC: begin
                // Perform the access and build the answer
                case (kind_r)
                    bmd_pkg::BMD_K_STATUS: begin
                        rbyte = status_r;
                        if (write_r) begin
                            status_nxt = wdata_r;
                        end
                    end
                    bmd_pkg::BMD_K_POINTER: begin
                        rbyte = pointer_r;
                        if (write_r) begin
                            pointer_nxt = wdata_r;
                        end
                    end
                    bmd_pkg::BMD_K_SFR: begin
                        rbyte = sfr_rdata;
                    end
                    bmd_pkg::BMD_K_GPR: begin
                        rbyte = gpr.rdata;
                    end
                    default: begin
                        rbyte = 8'h00;
                    end
                endcase
                // Writes answer with zero read data
                prdata_nxt = write_r ? 32'h00000000 : {`BMD_BYTE_ZERO, rbyte};
                pready_nxt = 1'b1;
                state_nxt = bmd_pkg::BMD_ST_RESP;
            end
            bmd_pkg::BMD_ST_RESP: begin
                // Answer stands one cycle, then back to idle
                state_nxt = bmd_pkg::BMD_ST_IDLE;
            end
            default: begin
                state_nxt = bmd_pkg::BMD_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    // Storage entries stay out of reset, like static RAM

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= bmd_pkg::BMD_ST_IDLE;
            kind_r <= bmd_pkg::BMD_K_NONE;
            gidx_r <= 7'h00;
            write_r <= 1'b0;
            wdata_r <= 8'h00;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            sfr_addr_r <= 8'h00;
            sfr_rd_r <= 1'b0;
            sfr_wr_r <= 1'b0;
            status_r <= `BMD_STATUS_RST;
            pointer_r <= `BMD_POINTER_RST;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            gidx_r <= gidx_nxt;
            write_r <= write_nxt;
            wdata_r <= wdata_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            sfr_addr_r <= sfr_addr_nxt;
            sfr_rd_r <= sfr_rd_nxt;
            sfr_wr_r <= sfr_wr_nxt;
            status_r <= status_nxt;
            pointer_r <= pointer_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop
    // Bank bit is a copy of status bit 5, not a second flop

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sfr_addr = sfr_addr_r;
    assign sfr_rd = sfr_rd_r;
    assign sfr_wr = sfr_wr_r;
    assign sfr_wdata = wdata_r;
    assign bank_select_bit = status_r[`BMD_BANK_BIT];
    assign machine_status = status_r;
    assign indirect_pointer = pointer_r;

endmodule

`default_nettype wire

/* testbench/bmd_sfr_model.sv */
// Model of the special function block on the side port.
// Assumes read data is wanted in the cycle of the read strobe.
`timescale 1ns/100ps
`default_nettype none
module bmd_sfr_model (
    // Clock
    input wire logic pclk,
    // Side port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata
);
    logic [7:0] regs [256];
    logic [7:0] last = 8'h00;

    // Store per full address, so each bank keeps its own copy
    always @(posedge pclk) begin
        if (sfr_wr) regs[sfr_addr] <= sfr_wdata;
        if (sfr_rd) last <= regs[sfr_addr];
    end

    // Inverted stale value while not read
    assign sfr_rdata = sfr_rd ? regs[sfr_addr] : ~last;
endmodule
`default_nettype wire

/* testbench/bmd_decode_monitor.sv */
// Checker on the ports of the decode block.
// Assumes the bind below and one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module bmd_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Side port and state
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic bank_select_bit,
    input wire logic [7:0] machine_status,
    input wire logic [7:0] indirect_pointer
);
    logic su;
    logic [6:0] off;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup cycle to a legal address
    assign su = psel && !penable && paddr[11:9] == 3'h0;
    assign off = paddr[8:2];

    ////////////////////////////////////////////////////////////////////
    a_bank_is_bit5:
    assert property (bank_select_bit == machine_status[5]) else $error("bank bit off");
    a_ok_latency:
    assert property (su |-> ##2 pready && !pslverr) else $error("late answer");
    a_err_latency:
    assert property (psel && !penable && paddr[11:9] != 3'h0 |-> ##1 pready && pslverr)
        else $error("no error answer");
    a_status_write:
    assert property (su && pwrite && off == 7'h03 |-> ##2 machine_status == pwdata[7:0])
        else $error("status not written");
    a_ptr_write:
    assert property (su && pwrite && off == 7'h04 |-> ##2 indirect_pointer == pwdata[7:0])
        else $error("pointer not written");
    a_gap_zero:
    assert property (su && !pwrite && bank_select_bit && off inside {[7'h40:7'h6F]}
        |-> ##2 prdata == 32'h00000000) else $error("gap read not zero");
    a_bank0_no_sfr:
    assert property (su && !bank_select_bit && off == 7'h0E
        |-> ##1 !sfr_rd && !sfr_wr) else $error("bank 0 strobe");
    a_bank1_sfr:
    assert property (su && bank_select_bit && off == 7'h0E
        |-> ##1 (sfr_rd || sfr_wr) && sfr_addr == 8'h8E) else $error("bank 1 no strobe");
    a_empty_ptr:
    assert property (su && !pwrite && off == 7'h00 && indirect_pointer[6:0] == 7'h00
        |-> ##2 prdata == 32'h00000000) else $error("indirect self read");

    // Main scenarios
    c_err: cover property (pready && pslverr);
    c_rd: cover property (sfr_rd);
    c_wr: cover property (sfr_wr);
endmodule

bind bmd_decode bmd_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .bank_select_bit(bank_select_bit),
    .machine_status(machine_status), .indirect_pointer(indirect_pointer));
`default_nettype wire

/* testbench/banked_data_memory_decode_tb_top.sv */
// Self-checking bench for the decode block over APB.
// Assumes the side port model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module banked_data_memory_decode_tb_top;
    typedef struct {logic w; logic [6:0] off; logic [7:0] d;} bmd_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sfr_rd, sfr_wr, bsel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, status, ptr;
    logic e;
    int failures = 0;
    int num_checks = 0;
    // Write rows carry data, read rows the byte expected
    bmd_row_s rows [29] = '{'{1, 7'h03, 8'h00}, '{1, 7'h20, 8'hA1}, '{1, 7'h7F, 8'hB2},
        '{1, 7'h1F, 8'h33}, '{1, 7'h07, 8'h44}, '{1, 7'h03, 8'h20}, '{1, 7'h20, 8'hC3},
        '{1, 7'h3F, 8'hD4}, '{0, 7'h7F, 8'hB2}, '{1, 7'h70, 8'h77}, '{1, 7'h40, 8'hEE},
        '{0, 7'h40, 8'h00}, '{1, 7'h0E, 8'h5A}, '{0, 7'h0E, 8'h5A}, '{0, 7'h03, 8'h20},
        '{1, 7'h03, 8'h00}, '{0, 7'h0E, 8'h00}, '{0, 7'h1F, 8'h33}, '{0, 7'h07, 8'h00},
        '{0, 7'h70, 8'h77}, '{0, 7'h20, 8'hA1}, '{1, 7'h04, 8'hBF}, '{0, 7'h00, 8'hD4},
        '{1, 7'h00, 8'h99}, '{1, 7'h03, 8'h20}, '{0, 7'h3F, 8'h99}, '{1, 7'h04, 8'h80},
        '{0, 7'h00, 8'h00}, '{0, 7'h04, 8'h80}};

    bmd_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .bank_select_bit(bsel), .machine_status(status), .indirect_pointer(ptr));
    bmd_sfr_model u_sfr (.pclk(pclk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

    // Verdict and end of run
    task automatic wrap_up;
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog
    initial begin
        #2000000;
        failures++;
        $display("mismatch %0t watchdog expired", $time);
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, {3'h0, rows[i].off, 2'h0}, rows[i].d);
            if (!rows[i].w) chk(r, {24'h000000, rows[i].d});
        end
        chk(bsel, 1'b1);
        apb(1'b0, 12'hE00, 8'h00);
        chk(e, 1'b1);
        chk(r, 32'h00000000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({status, ptr}, 16'h0000);
        chk({bsel, pready, pslverr, sfr_rd, sfr_wr}, 5'h00);
        chk(prdata, 32'h00000000);
        apb(1'b0, 12'h080, 8'h00);
        chk(r, 32'h000000A1);
        wrap_up;
    end
endmodule
`default_nettype wire
